// ---- disk_seq_pkg.sv ----
// shared constants and carrier types for the disk sector transfer sequencer
package disk_seq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_COUNT = 4'h2;
    localparam logic [3:0] REG_TRACK = 4'h3;
    localparam int CTRL_READ = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_READ_FMT = 2;
    localparam int CTRL_WRITE_FMT = 3;
    localparam int CTRL_GCLEAR = 7;
    localparam logic [11:0] COUNT_RESET = 12'h000;
    localparam logic [2:0] BIT_THREE = 3'h3;
    localparam logic [2:0] BIT_SEVEN = 3'h7;
    localparam logic [8:0] BYTE_END_FMT = 9'h10D;
    localparam logic [8:0] BYTE_END_DATA = 9'h0FF;
    localparam logic [1:0] OVR_CLEAR = 2'h0;

    typedef struct packed {
        logic byteReady;
        logic byteWanted;
        logic [7:0] data;
    } channel_in_s;

    typedef struct packed {
        logic dataStart;
        logic sectorMatchIn;
        logic readCountPulse;
        logic writeCountPulse;
        logic readOutputRegLoad;
        logic outputRegLoad;
        logic gatedBitSeven;
        logic addrCompareFail;
        logic defectiveTrack;
        logic parityFail;
    } serial_in_s;

    typedef struct packed {
        logic cylOverflow;
        logic overrun;
        logic addrErr;
        logic trackErr;
        logic parityErr;
    } err_s;
endpackage

// ---- disk_sector_transfer_sequencer.sv ----
// sector transfer sequencer: format starts, multisector, head switch, counters, overrun
// Operation
// - read format starts on sector match, opens gate
// - read format byte end at byte 269
// - write launch is normal start or format match
// - write format byte end at byte 269
// - format mode masks address and track errors
// - channel end seen only by another request
// - parity phase flags and final read request
// - answered request sets more data on phase two
// - more data forces match, starts next sector
// - final byte flag blocks requests, last request
// - unanswered request lets write finish complete
// - answered request blocks completion, sets more data
// - index seen set by index, cleared after sector
// - head switches on index, sector, more data
// - head one already: cylinder overflow sets examine
// - examine inhibits all disk writing
// - one twelve bit counter, bit and byte
// - counter cleared by sector mark or data start, counts bit pulses
// - bit field decoded at three and seven
// - byte field decoded at 269 or 255
// - track address driven from holding register
// - overrun after a revolution without match
// - overrun stages cleared idle, count index mark rises
// - second overrun stage survives sector match
// - request shown to channel, acknowledge clears it
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module disk_sector_transfer_sequencer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [disk_seq_pkg::ADDR_W-1:0] regAddr,
    input wire logic [disk_seq_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [disk_seq_pkg::DATA_W-1:0] regRdata,
    // drive pins
    input wire logic indexMarkPin,
    input wire logic sectorMarkPin,
    output logic [7:0] trackAddressOut,
    output logic headSelectFlag,
    output logic writeGate,
    output logic dataReadGate,
    // serialiser strobes
    input wire disk_seq_pkg::serial_in_s serialIn,
    output logic writeLaunch,
    output logic sectorByteEnd,
    output logic bit3Strobe,
    output logic bit7Strobe,
    output logic addrCompareDisable,
    output logic opCompletePulse,
    output logic examineFlag,
    output disk_seq_pkg::err_s errFlags,
    // selector channel
    input wire disk_seq_pkg::channel_in_s channelIn,
    output logic byteRequestFlag
);
    import disk_seq_pkg::*;

    typedef struct packed {
        logic [2:0] idxSync;
        logic [2:0] smSync;
        logic idxLvl;
        logic smLvl;
        logic [3:0] cmd;
        logic busy;
        logic [11:0] cnt;
        logic byteEnd;
        logic bit3;
        logic bit7;
        logic readGate;
        logic wrGate;
        logic launch;
        logic phase1;
        logic phase2;
        logic req;
        logic finalByte;
        logic wFinal;
        logic wSpare;
        logic wFinish;
        logic more;
        logic op_end_pulse;
        logic opDone;
        logic idxSeen;
        logic head;
        logic examine;
        logic [1:0] ovr;
        err_s err;
        logic [7:0] hold;
        logic [7:0] track;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic gclear;
    logic fmt;
    logic smatch;
    logic ack;
    logic idxRise;
    logic smRise;
    logic smFall;
    logic [8:0] byteIdx;

    always_comb begin
        state_next = state_reg;
        gclear = regWrite && regAddr == REG_CTRL && regWdata[CTRL_GCLEAR];
        fmt = state_reg.cmd[CTRL_READ_FMT] | state_reg.cmd[CTRL_WRITE_FMT];
        smatch = serialIn.sectorMatchIn | state_reg.more;
        ack = state_reg.req & (channelIn.byteReady | channelIn.byteWanted);
        // channel acknowledge clears the request; a request set later in this cycle wins
        if (ack) begin
            state_next.req = 1'b0;
        end

        // drive pins: three stages, a change counts once stages two and three agree
        state_next.idxSync = {state_reg.idxSync[1:0], indexMarkPin};
        state_next.smSync = {state_reg.smSync[1:0], sectorMarkPin};
        if (state_reg.idxSync[1] == state_reg.idxSync[2]) begin
            state_next.idxLvl = state_reg.idxSync[2];
        end
        if (state_reg.smSync[1] == state_reg.smSync[2]) begin
            state_next.smLvl = state_reg.smSync[2];
        end
        idxRise = state_next.idxLvl & ~state_reg.idxLvl;
        smRise = state_next.smLvl & ~state_reg.smLvl;
        smFall = ~state_next.smLvl & state_reg.smLvl;

        // bit and byte counter
        if (smRise || serialIn.dataStart) begin
            state_next.cnt = COUNT_RESET;
        end else if (serialIn.readCountPulse || serialIn.writeCountPulse) begin
            state_next.cnt = state_reg.cnt + 12'h001;
        end
        state_next.bit3 = state_next.cnt[2:0] == BIT_THREE;
        state_next.bit7 = state_next.cnt[2:0] == BIT_SEVEN;
        byteIdx = state_next.cnt[11:3];
        state_next.byteEnd = fmt ? byteIdx == BYTE_END_FMT
                                 : byteIdx == BYTE_END_DATA;

        // channel byte into the holding register, track address from it
        if (channelIn.byteReady) begin
            state_next.hold = channelIn.data;
        end
        state_next.track = state_reg.hold;

        // read start: normal data start or sector match in read format
        state_next.op_end_pulse = 1'b0;
        state_next.opDone = 1'b0;
        state_next.launch = 1'b0;
        if (state_reg.busy && !state_reg.readGate) begin
            if ((smatch && state_reg.cmd[CTRL_READ_FMT])
                    || (serialIn.dataStart && state_reg.cmd[CTRL_READ])) begin
                state_next.readGate = 1'b1;
                state_next.more = 1'b0;
            end
        end

        // read parity check phases
        if (state_reg.readGate && serialIn.readOutputRegLoad) begin
            if (state_reg.phase2) begin
                state_next.op_end_pulse = 1'b1;
            end else if (state_reg.phase1) begin
                state_next.phase2 = 1'b1;
                state_next.req = 1'b1;
            end else if (state_reg.byteEnd) begin
                state_next.phase1 = 1'b1;
            end else begin
                state_next.req = 1'b1;
            end
        end
        if (state_reg.phase2 && !state_reg.op_end_pulse && !state_reg.req && state_reg.readGate
                && !state_reg.more && serialIn.readOutputRegLoad) begin
            state_next.more = 1'b1;
        end

        // write start and write byte sequence
        if (state_reg.busy && !state_reg.wrGate && !state_reg.examine
                && ((serialIn.dataStart && state_reg.cmd[CTRL_WRITE])
                || (state_reg.cmd[CTRL_WRITE_FMT] && smatch))) begin
            state_next.launch = 1'b1;
            state_next.wrGate = 1'b1;
            state_next.req = 1'b1;
            state_next.more = 1'b0;
        end
        // each load asks for a byte until wFinal sets; the load ending the final byte asks for the last one
        if (state_reg.wrGate && serialIn.outputRegLoad && !state_reg.wFinal) begin
            state_next.req = 1'b1;
        end
        if (state_reg.wrGate && serialIn.gatedBitSeven) begin
            state_next.finalByte = state_reg.finalByte | state_reg.byteEnd;
            state_next.wFinal = state_reg.finalByte;
            state_next.wSpare = state_reg.wFinal;
            state_next.wFinish = state_reg.wSpare;
            if (state_reg.wSpare && !state_reg.wFinish) begin
                state_next.op_end_pulse = 1'b1;
            end
        end
        if (state_next.wFinal && !state_reg.wFinal && !state_reg.req) begin
            state_next.more = 1'b1;
        end

        // operation end becomes completion only when the last request stayed open
        if (state_reg.op_end_pulse) begin
            state_next.readGate = 1'b0;
            state_next.phase1 = 1'b0;
            state_next.phase2 = 1'b0;
            if (state_reg.req) begin
                state_next.opDone = 1'b1;
                state_next.busy = 1'b0;
                state_next.more = 1'b0;
                state_next.cmd = 4'h0;
            end
        end
        if (smRise) begin
            state_next.finalByte = 1'b0;
            state_next.wFinal = 1'b0;
            state_next.wSpare = 1'b0;
            state_next.wFinish = 1'b0;
            state_next.wrGate = 1'b0;
        end
        if (state_reg.examine) begin
            state_next.wrGate = 1'b0;
        end

        // index seen, head switch, cylinder overflow
        if (idxRise) begin
            state_next.idxSeen = 1'b1;
        end else if (smFall) begin
            state_next.idxSeen = 1'b0;
        end
        if (smRise && state_reg.idxSeen && state_reg.more) begin
            if (!state_reg.head) begin
                state_next.head = 1'b1;
            end else begin
                state_next.err.cylOverflow = 1'b1;
                state_next.examine = 1'b1;
            end
        end

        // overrun stages
        if (!state_reg.busy) begin
            state_next.ovr = OVR_CLEAR;
        end else if (smatch) begin
            state_next.ovr[0] = 1'b0;
        end else if (idxRise) begin
            state_next.ovr = {state_reg.ovr[1] | state_reg.ovr[0], ~state_reg.ovr[0]};
        end
        if (state_reg.ovr[1]) begin
            state_next.err.overrun = 1'b1;
        end

        // address phase errors are never set in format mode
        state_next.err.addrErr |= serialIn.addrCompareFail & ~fmt;
        state_next.err.trackErr |= serialIn.defectiveTrack & ~fmt;
        state_next.err.parityErr |= serialIn.parityFail;

        // register port
        if (regWrite && regAddr == REG_CTRL && !gclear) begin
            state_next.cmd = regWdata[3:0];
            state_next.busy = |regWdata[3:0];
        end
        state_next.rdata = '0;
        if (regRead) begin
            unique case (regAddr)
                REG_CTRL: state_next.rdata = {11'h000, state_reg.busy, state_reg.cmd};
                REG_STATUS: state_next.rdata = {4'h0, state_reg.more, state_reg.req,
                    state_reg.idxSeen, state_reg.head, state_reg.examine, state_reg.ovr,
                    state_reg.err};
                REG_COUNT: state_next.rdata = {4'h0, state_reg.cnt};
                REG_TRACK: state_next.rdata = {8'h00, state_reg.hold};
                default: state_next.rdata = '0;
            endcase
        end

        // general clear resets the sequencer, keeping pin synchronisers
        if (gclear) begin
            state_next = '0;
            state_next.idxSync = state_reg.idxSync;
            state_next.smSync = state_reg.smSync;
            state_next.idxLvl = state_reg.idxLvl;
            state_next.smLvl = state_reg.smLvl;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdata = state_reg.rdata;
    assign trackAddressOut = state_reg.track;
    assign headSelectFlag = state_reg.head;
    assign writeGate = state_reg.wrGate;
    assign dataReadGate = state_reg.readGate;
    assign writeLaunch = state_reg.launch;
    assign sectorByteEnd = state_reg.byteEnd;
    assign bit3Strobe = state_reg.bit3;
    assign bit7Strobe = state_reg.bit7;
    assign addrCompareDisable = state_reg.more;
    assign opCompletePulse = state_reg.opDone;
    assign examineFlag = state_reg.examine;
    assign errFlags = state_reg.err;
    assign byteRequestFlag = state_reg.req;

    // checks
    sequence formatMatch;
        state_reg.busy && state_reg.cmd[CTRL_READ_FMT] && !state_reg.readGate
            && (serialIn.sectorMatchIn || state_reg.more) && !gclear;
    endsequence

    sequence writeOpen;
        state_reg.wrGate && !state_reg.examine;
    endsequence

    a_format_read_open: assert property (@(posedge mclk) disable iff (!rst_b)
        formatMatch |=> dataReadGate) else $error("read format did not open gate");

    a_byte_end_decode: assert property (@(posedge mclk) disable iff (!rst_b)
        sectorByteEnd |-> $past(state_next.cnt[11:3]) == (
            $past(state_reg.cmd[CTRL_READ_FMT] | state_reg.cmd[CTRL_WRITE_FMT])
            ? BYTE_END_FMT : BYTE_END_DATA))
        else $error("byte end at wrong byte");

    a_launch_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(writeLaunch) |-> $past(serialIn.dataStart && state_reg.cmd[CTRL_WRITE]
            || state_reg.cmd[CTRL_WRITE_FMT] && (serialIn.sectorMatchIn || state_reg.more)))
        else $error("write launch without cause");

    a_examine_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
        examineFlag |=> !writeGate) else $error("write gate during examine");

    a_fmt_err_mask: assert property (@(posedge mclk) disable iff (!rst_b)
        (fmt && !errFlags.addrErr && !gclear) |=> !errFlags.addrErr)
        else $error("address error in format mode");

    a_head_overflow: assert property (@(posedge mclk) disable iff (!rst_b)
        (smRise && state_reg.idxSeen && state_reg.more && state_reg.head && !gclear)
        |=> errFlags.cylOverflow && examineFlag && headSelectFlag)
        else $error("overflow not flagged");

    a_overrun_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_reg.ovr[1] && state_reg.busy && !gclear) ##1 !gclear |=> errFlags.overrun)
        else $error("overrun lost");

    a_ack_clears_req: assert property (@(posedge mclk) disable iff (!rst_b)
        (ack && !(state_next.req && !state_reg.req) && !state_reg.op_end_pulse) ##1 writeOpen
        |-> !byteRequestFlag || $past(state_next.req))
        else $error("channel answer did not clear request");

    a_complete_needs_req: assert property (@(posedge mclk) disable iff (!rst_b)
        opCompletePulse |-> $past(state_reg.op_end_pulse && state_reg.req, 1))
        else $error("completion with answered request");

    a_idle_overrun_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        !state_reg.busy |=> state_reg.ovr == OVR_CLEAR)
        else $error("overrun stages counted while idle");
endmodule

// ---- channel_partner_model.sv ----
// selector channel model answering byte requests with a chosen lag
`timescale 1ns/1ps
module channel_partner_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // control from bench
    input wire logic answerEnable,
    input wire logic [1:0] lag,
    input wire logic [7:0] nextData,
    // channel side
    input wire logic byteRequestFlag,
    output disk_seq_pkg::channel_in_s channelIn,
    output logic [7:0] sentData
);
    import disk_seq_pkg::*;
    logic [1:0] waitCount;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            channelIn <= '0;
            sentData <= 8'h00;
            waitCount <= 2'h0;
        end else if (channelIn.byteReady) begin
            // one answer per request, then the data lines stop holding
            channelIn.byteReady <= 1'b0;
            channelIn.data <= ~channelIn.data;
        end else if (byteRequestFlag && answerEnable) begin
            if (waitCount == lag) begin
                channelIn.byteReady <= 1'b1; // answer with next byte
                channelIn.data <= nextData;
                sentData <= nextData;
                waitCount <= 2'h0;
            end else begin
                waitCount <= waitCount + 2'h1;
            end
        end else begin
            channelIn.data <= ~channelIn.data; // no answer leaves request standing
        end
    end
endmodule

// ---- tb_disk_sector_transfer_sequencer.sv ----
// self-checking bench for the disk sector transfer sequencer
`timescale 1ns/1ps
module tb_disk_sector_transfer_sequencer;
    import disk_seq_pkg::*;
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] value;
    } note_s;
    localparam int DS = 9;
    localparam int SMI = 8;
    localparam int RCP = 7;
    localparam int WCP = 6;
    localparam int GBS = 3;
    localparam int ACF = 2;
    localparam int DFT = 1;
    localparam int PF = 0;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    logic indexMarkPin = 1'b0;
    logic sectorMarkPin = 1'b0;
    logic [7:0] trackAddressOut;
    logic headSelectFlag, writeGate, dataReadGate, writeLaunch, sectorByteEnd;
    logic bit3Strobe, bit7Strobe, addrCompareDisable, opCompletePulse, examineFlag;
    logic byteRequestFlag;
    logic readPending = 1'b0;
    logic answerEnable = 1'b1;
    logic [1:0] lag;
    logic [7:0] nextData, sentData;
    serial_in_s serialIn = '0;
    err_s errFlags;
    channel_in_s channelIn;
    note_s notes[$];
    note_s note;
    int mismatches = 0;
    int comparisons = 0;
    int seed = 32'hdf7e;
    int n;
    int completions = 0;
    always #4 mclk = ~mclk;
    disk_sector_transfer_sequencer dut_u (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .indexMarkPin(indexMarkPin), .sectorMarkPin(sectorMarkPin),
        .trackAddressOut(trackAddressOut), .headSelectFlag(headSelectFlag),
        .writeGate(writeGate), .dataReadGate(dataReadGate), .serialIn(serialIn),
        .writeLaunch(writeLaunch), .sectorByteEnd(sectorByteEnd), .bit3Strobe(bit3Strobe),
        .bit7Strobe(bit7Strobe), .addrCompareDisable(addrCompareDisable),
        .opCompletePulse(opCompletePulse), .examineFlag(examineFlag), .errFlags(errFlags),
        .channelIn(channelIn), .byteRequestFlag(byteRequestFlag));
    channel_partner_model partner_u (.mclk(mclk), .rst_b(rst_b), .answerEnable(answerEnable),
        .lag(lag), .nextData(nextData), .byteRequestFlag(byteRequestFlag),
        .channelIn(channelIn), .sentData(sentData));
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        comparisons++;
        if (seen !== expected) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watcher: read data stand in the cycle after the strobe, settled at the falling edge
    always @(posedge mclk) readPending <= regRead;
    always @(negedge mclk) begin
        if (readPending) begin
            note = notes.pop_front();
            check(regRdata & note.mask, note.value);
        end
        if (opCompletePulse) begin
            completions++;
        end
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] v);
        notes.push_back('{mask: m, value: v});
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
    endtask
    task automatic pulse(input int idx);
        serialIn[idx] <= 1'b1;
        @(posedge mclk);
        serialIn <= '0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic counts(input int k);
        for (int i = 0; i < k; i++) begin
            serialIn <= (i % 2) ? serial_in_s'(10'h080) : serial_in_s'(10'h040);
            @(posedge mclk);
        end
        serialIn <= '0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic mark(input logic isIndex);
        if (isIndex) indexMarkPin <= 1'b1;
        else sectorMarkPin <= 1'b1;
        repeat (5) @(posedge mclk);
        indexMarkPin <= 1'b0;
        sectorMarkPin <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    // format sector up to byte end, then four gated bit seven strobes
    task automatic sector_tail();
        counts(2152);
        repeat (4) pulse(GBS);
    endtask
    initial begin
        lag = 2'h2;
        nextData = 8'h00;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(REG_STATUS, 16'hFFFF, 16'h0000);
        rd(4'h9, 16'hFFFF, 16'h0000);
        // counter fields and strobes
        n = 8 * ($unsigned($random(seed)) % 30) + 3;
        pulse(DS);
        counts(n);
        rd(REG_COUNT, 16'h0FFF, 16'(n));
        check({bit7Strobe, bit3Strobe}, 16'h0001);
        counts(4);
        check({bit7Strobe, bit3Strobe}, 16'h0002);
        mark(1'b0);
        rd(REG_COUNT, 16'h0FFF, 16'h0000);
        // byte end position, data then format
        wr(REG_CTRL, 16'h0001);
        pulse(DS);
        counts(2039);
        check(sectorByteEnd, 16'h0000);
        counts(1);
        check(sectorByteEnd, 16'h0001);
        wr(REG_CTRL, 16'h0080);
        wr(REG_CTRL, 16'h0004);
        pulse(DS);
        counts(2040);
        check(sectorByteEnd, 16'h0000);
        counts(112);
        check(sectorByteEnd, 16'h0001);
        // errors in format and normal modes
        check(dataReadGate, 16'h0000);
        pulse(ACF);
        pulse(DFT);
        pulse(PF);
        rd(REG_STATUS, 16'h0007, 16'h0001);
        wr(REG_CTRL, 16'h0080);
        wr(REG_CTRL, 16'h0004);
        pulse(SMI);
        check(dataReadGate, 16'h0001);
        wr(REG_CTRL, 16'h0080);
        wr(REG_CTRL, 16'h0001);
        pulse(ACF);
        rd(REG_STATUS, 16'h0004, 16'h0004);
        wr(REG_CTRL, 16'h0080);
        rd(REG_STATUS, 16'h001F, 16'h0000);
        // write format launch and channel answer
        wr(REG_CTRL, 16'h0008);
        nextData <= 8'($random(seed));
        serialIn[SMI] <= 1'b1;
        @(posedge mclk);
        serialIn <= '0;
        #1 check(writeLaunch, 16'h0001);
        @(posedge mclk);
        #1 check(byteRequestFlag, 16'h0001);
        n = 0;
        while (byteRequestFlag === 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 20) begin
            mismatches++; // request never answered
        end
        repeat (3) @(posedge mclk);
        check(trackAddressOut, 16'(sentData));
        // multisector write format: answered last request, head switch, overflow
        check(writeGate, 16'h0001);
        sector_tail();
        check(addrCompareDisable, 16'h0001);
        check(16'(completions), 16'h0000);
        rd(REG_CTRL, 16'h001F, 16'h0018);
        mark(1'b1);
        mark(1'b0);
        check({headSelectFlag, writeGate, addrCompareDisable}, 16'h0006);
        sector_tail();
        mark(1'b1);
        mark(1'b0);
        check({headSelectFlag, examineFlag}, 16'h0003);
        check({writeGate, errFlags.cylOverflow}, 16'h0001);
        // unanswered last request completes the write
        wr(REG_CTRL, 16'h0080);
        answerEnable <= 1'b0;
        wr(REG_CTRL, 16'h0008);
        pulse(SMI);
        sector_tail();
        check(16'(completions), 16'h0001);
        rd(REG_CTRL, 16'h001F, 16'h0000);
        // index seen and overrun
        wr(REG_CTRL, 16'h0080);
        wr(REG_CTRL, 16'h0001);
        mark(1'b1);
        rd(REG_STATUS, 16'h0200, 16'h0200);
        mark(1'b0);
        rd(REG_STATUS, 16'h0208, 16'h0000);
        mark(1'b1);
        mark(1'b0);
        rd(REG_STATUS, 16'h0008, 16'h0008);
        pulse(SMI);
        check(errFlags.overrun, 16'h0001);
        final_report();
    end
endmodule
